// File: lpp_consts.svh
// Register indices, field positions, reset values and level constants of the luma pipeline.
`ifndef LPP_CONSTS_SVH
`define LPP_CONSTS_SVH
`define LPP_IDX_MODE2 12'h401
`define LPP_IDX_BRIGHT 12'h414
`define LPP_IDX_CONTRAST 12'h415
`define LPP_IDX_LUMA_CTL 12'h416
`define LPP_IDX_HSCALE0 12'h418
`define LPP_IDX_HSCALE1 12'h419
`define LPP_IDX_HSCALE2 12'h41a
`define LPP_IDX_WHITE3 12'h4a2
`define LPP_IDX_STD 12'h4f0
`define LPP_IDX_STATUS 12'h4f1
`define LPP_WLE_BIT 3
`define LPP_WTE_BIT 0
`define LPP_CORE_LSB 0
`define LPP_PSEL_LSB 2
`define LPP_RANGE_LSB 4
`define LPP_PEAK_EN_BIT 6
`define LPP_STD_SETUP_BIT 0
`define LPP_STD_625_BIT 1
`define LPP_MODE2_RST 8'h08
`define LPP_CONTRAST_RST 8'h80
`define LPP_GAIN_UNITY 8'h80
`define LPP_GAIN_MIN 8'h40
`define LPP_WHITE_100 10'h320
`define LPP_WHITE_110 10'h370
`define LPP_WHITE_HYST 10'h010
`define LPP_BACK_PORCH 12'h0f0
`define LPP_SETUP 12'h02a
`define LPP_SCALE_525 9'h0b4
`define LPP_SCALE_625 9'h0a8
`define LPP_SPI_BLACK_Q7 24'h00_2000
`define LPP_HS_T1 24'h08_0000
`define LPP_HS_T2 24'h10_0000
`define LPP_PK_K0 5'h03
`define LPP_PK_K1 5'h05
`define LPP_PK_K2 5'h08
`define LPP_PK_K3 5'h0a
`define LPP_CSC_525 9'h0e0
`define LPP_CSC_625 9'h0e4
`define LPP_CSC_FULL 9'h100
`define LPP_CORE_T1 13'h0010
`define LPP_CORE_T2 13'h0020
`define LPP_CORE_T3 13'h0040
`define LPP_LO_SPI 10'h040
`define LPP_LO_BTB 10'h004
`define LPP_HI_SPI 10'h3f8
`define LPP_LATENCY 9
`endif

// File: lpp_pkg.sv
// Types shared by the luma post-processing pipeline.
package lpp_pkg;
	typedef logic [11:0] lpp_idx_t;
	typedef enum logic [1:0] {
		LPP_LPF_BYPASS = 2'h0,
		LPP_LPF_MILD = 2'h1,
		LPP_LPF_MED = 2'h2,
		LPP_LPF_STRONG = 2'h3
	} lpp_lpf_t;
endpackage

// File: lpp_stream_model.sv
// Model of the separator that feeds luma in and the scaler that takes it out.
`timescale 1ns/10ps
module lpp_stream_model (
	input wire logic clk_i,
	input wire logic [9:0] res_i,
	input wire logic res_valid_i,
	output logic [9:0] samp_o,
	output logic samp_valid_o
);
	logic [31:0] cyc_cnt;
	logic [31:0] t_in;
	logic [31:0] lat;
	logic [9:0] last_y;
	logic [9:0] req_v;
	int req_n;
	int n_out;

	initial begin
		samp_o = 10'h155;
		samp_valid_o = 1'b0;
		cyc_cnt = 32'h0000_0000;
		t_in = 32'h0000_0000;
		lat = 32'h0000_0000;
		last_y = 10'h000;
		req_v = 10'h000;
		req_n = 0;
		n_out = 0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Queue a burst of identical samples; the clocked block sends them back to back.
	task automatic send(input logic [9:0] v, input int n);
		req_v <= v;
		req_n <= n;
	endtask

	// The idle data lines toggle so that no stale sample can pass for a real one.
	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 32'h0000_0001;
		if (req_n > 0) begin
			samp_o <= req_v;
			samp_valid_o <= 1'b1;
			req_n <= req_n - 1;
		end else begin
			samp_o <= ~samp_o;
			samp_valid_o <= 1'b0;
		end
		if (samp_valid_o) begin
			t_in <= cyc_cnt;
		end
		if (res_valid_i === 1'b1) begin
			lat <= cyc_cnt - t_in;
			last_y <= res_i;
			n_out <= n_out + 1;
		end
	end
endmodule

// File: lpp_top.sv
// Luma post-processing pipeline with its Wishbone register file.
`timescale 1ns/10ps
`include "lpp_consts.svh"
// Behaviour
// - White crush lowers gain above peak white.
// - White crush on by default, software-disabled.
// - Threshold 110 IRE when enabled, else 100.
// - Remove back porch, optional setup, then scale.
// - Low-pass shape chosen from horizontal scale.
// - No scaling selects the bypass shape.
// - Peaking after low-pass, bypassed unless enabled.
// - Peaking gain select picks four boosts.
// - Contrast multiplies, 0x80 is unity.
// - Colour-space gain from standard and range.
// - Brightness adds eight times signed value.
// - Coring zeroes small-magnitude values.
// - Range 00 limits to 64..1016.
// - Range 01 limits to 4..1016.
// - Range 1x passes 0..1023 unlimited.
// - Stages run in the fixed documented order.
// - Samples in from separator, out to scaler.
module lpp_top #(
	parameter int ADR_W = 14
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [ADR_W-1:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic ack_o,
	input wire logic [9:0] y_i,
	input wire logic y_valid_i,
	output logic [9:0] y_o,
	output logic y_valid_o
);
	////////////////////////////////////////////////////////////////////////////////
	logic ack_reg;
	logic [31:0] dat_reg;
	logic [7:0] mode2_reg;
	logic [7:0] bright_reg;
	logic [7:0] contrast_reg;
	logic [7:0] luma_ctl_reg;
	logic [23:0] hscale_reg;
	logic [7:0] white3_reg;
	logic [7:0] std_reg;
	logic [7:0] wgain_reg;
	logic [8:0] vld_reg;
	logic [9:0] s1_reg, s2_reg, s3_reg, s4_reg, s5_reg, y_reg;
	logic [9:0] lp1_reg, lp2_reg, pk1_reg, pk2_reg;
	logic signed [11:0] s6_reg;
	logic signed [12:0] s7_reg, s8_reg;
	lpp_pkg::lpp_idx_t idx;
	logic req, wr;
	logic [31:0] rd_next;
	logic [1:0] range;

	assign idx = adr_i[13:2];
	assign req = cyc_i && stb_i && !ack_reg;
	assign wr = req && we_i && sel_i[0];
	assign range = luma_ctl_reg[`LPP_RANGE_LSB +: 2];
	assign ack_o = ack_reg;
	assign dat_o = dat_reg;
	assign y_o = y_reg;
	assign y_valid_o = vld_reg[8];

	function automatic logic [9:0] rnd_sat(input logic signed [23:0] v, input int sh);
		logic signed [23:0] r;
		r = (v + (24'sh1 <<< (sh - 1))) >>> sh;
		if (r < 0)
			rnd_sat = 10'h000;
		else if (r > 24'sh3ff)
			rnd_sat = 10'h3ff;
		else
			rnd_sat = r[9:0];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Single-cycle answer: ack rises one edge after the request and drops after one cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ack_reg <= 1'b0;
		else
			ack_reg <= req;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode2_reg <= `LPP_MODE2_RST;
			bright_reg <= 8'h00;
			contrast_reg <= `LPP_CONTRAST_RST;
			luma_ctl_reg <= 8'h00;
			hscale_reg <= 24'h00_0000;
			white3_reg <= 8'h00;
			std_reg <= 8'h00;
		end else if (wr) begin
			case (idx)
				`LPP_IDX_MODE2: mode2_reg <= dat_i[7:0];
				`LPP_IDX_BRIGHT: bright_reg <= dat_i[7:0];
				`LPP_IDX_CONTRAST: contrast_reg <= dat_i[7:0];
				`LPP_IDX_LUMA_CTL: luma_ctl_reg <= dat_i[7:0];
				`LPP_IDX_HSCALE0: hscale_reg[7:0] <= dat_i[7:0];
				`LPP_IDX_HSCALE1: hscale_reg[15:8] <= dat_i[7:0];
				`LPP_IDX_HSCALE2: hscale_reg[23:16] <= dat_i[7:0];
				`LPP_IDX_WHITE3: white3_reg <= dat_i[7:0];
				`LPP_IDX_STD: std_reg <= dat_i[7:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		case (idx)
			`LPP_IDX_MODE2: rd_next = {24'h00_0000, mode2_reg};
			`LPP_IDX_BRIGHT: rd_next = {24'h00_0000, bright_reg};
			`LPP_IDX_CONTRAST: rd_next = {24'h00_0000, contrast_reg};
			`LPP_IDX_LUMA_CTL: rd_next = {24'h00_0000, luma_ctl_reg};
			`LPP_IDX_HSCALE0: rd_next = {24'h00_0000, hscale_reg[7:0]};
			`LPP_IDX_HSCALE1: rd_next = {24'h00_0000, hscale_reg[15:8]};
			`LPP_IDX_HSCALE2: rd_next = {24'h00_0000, hscale_reg[23:16]};
			`LPP_IDX_WHITE3: rd_next = {24'h00_0000, white3_reg};
			`LPP_IDX_STD: rd_next = {24'h00_0000, std_reg};
			`LPP_IDX_STATUS: rd_next = {14'h0000, y_reg, wgain_reg};
			default: rd_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			dat_reg <= 32'h0000_0000;
		else if (req && !we_i)
			dat_reg <= rd_next;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Every stage registers once per clock, so latency is fixed at nine cycles.
	always_ff @(posedge clk_i) begin
		if (rst_i)
			vld_reg <= 9'h000;
		else
			vld_reg <= {vld_reg[7:0], y_valid_i};
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stage 1: white crush gain, adapted one step per valid sample.
	logic [9:0] wc_thr;
	logic [9:0] s1_next;
	logic wle;
	assign wle = mode2_reg[`LPP_WLE_BIT];
	assign wc_thr = white3_reg[`LPP_WTE_BIT] ? `LPP_WHITE_110 : `LPP_WHITE_100;
	assign s1_next = rnd_sat($signed({6'h00, {8'h00, y_i} * {10'h000, wgain_reg}}), 7);

	always_ff @(posedge clk_i) begin
		if (rst_i)
			wgain_reg <= `LPP_GAIN_UNITY;
		else if (!wle)
			wgain_reg <= `LPP_GAIN_UNITY;
		else if (y_valid_i) begin
			if (s1_next > wc_thr && wgain_reg > `LPP_GAIN_MIN)
				wgain_reg <= wgain_reg - 8'h01;
			else if (s1_next < wc_thr - `LPP_WHITE_HYST && wgain_reg < `LPP_GAIN_UNITY)
				wgain_reg <= wgain_reg + 8'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			s1_reg <= 10'h000;
		else
			s1_reg <= s1_next;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stage 2: back porch and setup removal, then scaling to interface levels.
	logic signed [11:0] lvl_t;
	logic [8:0] lvl_scale;
	assign lvl_t = $signed({2'b00, s1_reg} - `LPP_BACK_PORCH
		- (std_reg[`LPP_STD_SETUP_BIT] ? `LPP_SETUP : 12'h000));
	assign lvl_scale = std_reg[`LPP_STD_625_BIT] ? `LPP_SCALE_625 : `LPP_SCALE_525;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			s2_reg <= 10'h000;
		else
			s2_reg <= rnd_sat(24'(lvl_t) * 24'($signed(lvl_scale))
				+ $signed(`LPP_SPI_BLACK_Q7), 7);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stage 3: low-pass, shape chosen from the horizontal scale factor.
	lpp_pkg::lpp_lpf_t lpf_sel;
	logic [11:0] lpf_sum;
	always_comb begin
		if (hscale_reg == 24'h00_0000)
			lpf_sel = lpp_pkg::LPP_LPF_BYPASS;
		else if (hscale_reg < `LPP_HS_T1)
			lpf_sel = lpp_pkg::LPP_LPF_MILD;
		else if (hscale_reg < `LPP_HS_T2)
			lpf_sel = lpp_pkg::LPP_LPF_MED;
		else
			lpf_sel = lpp_pkg::LPP_LPF_STRONG;
	end

	always_comb begin
		case (lpf_sel)
			lpp_pkg::LPP_LPF_MILD: lpf_sum = {s2_reg, 1'b0} + {2'b00, s2_reg} + {2'b00, lp1_reg};
			lpp_pkg::LPP_LPF_MED: lpf_sum = {1'b0, s2_reg, 1'b0} + {2'b00, lp1_reg}
				+ {2'b00, lp2_reg};
			lpp_pkg::LPP_LPF_STRONG: lpf_sum = {2'b00, s2_reg} + {1'b0, lp1_reg, 1'b0}
				+ {2'b00, lp2_reg};
			default: lpf_sum = {s2_reg, 2'b00};
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lp1_reg <= 10'h000;
			lp2_reg <= 10'h000;
		end else if (vld_reg[1]) begin
			lp1_reg <= s2_reg;
			lp2_reg <= lp1_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			s3_reg <= 10'h000;
		else
			s3_reg <= rnd_sat($signed({12'h000, lpf_sum}), 2);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stage 4: peaking adds a scaled high-pass term to the newest sample, s3_reg.
	logic signed [12:0] pk_hp;
	logic [4:0] pk_k;
	assign pk_hp = $signed({2'b00, s3_reg, 1'b0}) - $signed({3'b000, pk1_reg})
		- $signed({3'b000, pk2_reg});
	always_comb begin
		case (luma_ctl_reg[`LPP_PSEL_LSB +: 2])
			2'h0: pk_k = `LPP_PK_K0;
			2'h1: pk_k = `LPP_PK_K1;
			2'h2: pk_k = `LPP_PK_K2;
			default: pk_k = `LPP_PK_K3;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pk1_reg <= 10'h000;
			pk2_reg <= 10'h000;
		end else if (vld_reg[2]) begin
			pk1_reg <= s3_reg;
			pk2_reg <= pk1_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			s4_reg <= 10'h000;
		else if (luma_ctl_reg[`LPP_PEAK_EN_BIT])
			s4_reg <= rnd_sat(24'(pk_hp) * 24'($signed({1'b0, pk_k}))
				+ $signed({10'h000, s3_reg, 4'h0}), 4);
		else
			s4_reg <= s3_reg;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stages 5 to 7: contrast, colour-space gain, brightness offset.
	logic [8:0] csc_k;
	assign csc_k = range[1] ? `LPP_CSC_FULL
		: (std_reg[`LPP_STD_625_BIT] ? `LPP_CSC_625 : `LPP_CSC_525);

	always_ff @(posedge clk_i) begin
		if (rst_i)
			s5_reg <= 10'h000;
		else
			s5_reg <= rnd_sat($signed({6'h00, {8'h00, s4_reg} * {10'h000, contrast_reg}}),
				7);
	end

	// The colour-space product is kept unclipped; limiting happens at the last stage.
	always_ff @(posedge clk_i) begin
		if (rst_i)
			s6_reg <= 12'sh000;
		else
			s6_reg <= 12'(({9'h000, s5_reg} * {10'h000, csc_k} + 19'h00080) >> 8);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			s7_reg <= 13'sh0000;
		else
			s7_reg <= 13'(s6_reg) + 13'($signed(bright_reg)) * 13'sd8;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stage 8: coring, then stage 9: range saturation.
	logic [12:0] core_thr;
	logic [12:0] s7_mag;
	assign s7_mag = s7_reg[12] ? 13'(-s7_reg) : s7_reg;
	always_comb begin
		case (luma_ctl_reg[`LPP_CORE_LSB +: 2])
			2'h1: core_thr = `LPP_CORE_T1;
			2'h2: core_thr = `LPP_CORE_T2;
			2'h3: core_thr = `LPP_CORE_T3;
			default: core_thr = 13'h0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			s8_reg <= 13'sh0000;
		else if (s7_mag < core_thr)
			s8_reg <= 13'sh0000;
		else
			s8_reg <= s7_reg;
	end

	logic [9:0] rng_lo, rng_hi, s8_sat;
	assign s8_sat = rnd_sat(24'(s8_reg), 0);
	always_comb begin
		case (range)
			2'h0: begin
				rng_lo = `LPP_LO_SPI;
				rng_hi = `LPP_HI_SPI;
			end
			2'h1: begin
				rng_lo = `LPP_LO_BTB;
				rng_hi = `LPP_HI_SPI;
			end
			default: begin
				rng_lo = 10'h000;
				rng_hi = 10'h3ff;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			y_reg <= 10'h000;
		else if (s8_sat < rng_lo)
			y_reg <= rng_lo;
		else if (s8_sat > rng_hi)
			y_reg <= rng_hi;
		else
			y_reg <= s8_sat;
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	latency_fixed_a: assert property (y_valid_i |-> ##9 y_valid_o) else $error("latency wrong");
	crush_off_a: assert property (!wle |=> wgain_reg == 8'h80) else $error("gain not unity");
	crush_step_a: assert property (wle && y_valid_i && s1_next > wc_thr && wgain_reg > 8'h40
		|=> wgain_reg == $past(wgain_reg) - 8'h01) else $error("gain not lowered");
	white_thr_a: assert property (white3_reg[0] |-> wc_thr == 10'h370) else $error("thr");
	lpf_bypass_a: assert property (hscale_reg == 24'h0 && $stable(hscale_reg)
		|=> s3_reg == $past(s2_reg)) else $error("lpf not bypassed");
	peak_off_a: assert property (!luma_ctl_reg[6] |=> s4_reg == $past(s3_reg))
		else $error("peaking not bypassed");
	core_zero_a: assert property (luma_ctl_reg[1:0] == 2'h3 && s7_mag < 13'd64
		|=> s8_reg == 13'sd0) else $error("coring missed");
	range_spi_a: assert property (range == 2'h0 && $stable(range) |=> y_reg >= 10'd64
		&& y_reg <= 10'd1016) else $error("range 00 broken");
	range_btb_a: assert property (range == 2'h1 && $stable(range) |=> y_reg >= 10'd4
		&& y_reg <= 10'd1016) else $error("range 01 broken");
	range_full_a: assert property (range[1] && s8_reg >= 0 && s8_reg <= 13'sd1023
		|=> y_reg == $past(s8_reg[9:0])) else $error("range 1x limited");
	bright_add_a: assert property (1'b1 |=> s7_reg == 13'($past(s6_reg))
		+ 13'($signed($past(bright_reg))) * 13'sd8) else $error("brightness");
	ack_pulse_a: assert property (ack_reg |=> !ack_reg) else $error("ack held");

	stream_c: cover property (y_valid_i ##9 y_valid_o);
	crush_c: cover property (wle && wgain_reg < 8'h80);
	peak_c: cover property (luma_ctl_reg[6] && vld_reg[3]);
	write_c: cover property (wr && idx == 12'h416);
endmodule

// File: luma_post_processing_bench.sv
// Self-checking bench for the luma post-processing pipeline.
`timescale 1ns/10ps
`include "lpp_consts.svh"
module luma_post_processing_bench;
	logic clk_i;
	logic rst_i;
	logic [13:0] adr_i;
	logic [31:0] dat_i;
	logic [31:0] dat_o;
	logic we_i;
	logic [3:0] sel_i;
	logic cyc_i;
	logic stb_i;
	logic ack_o;
	logic [9:0] y_i;
	logic y_valid_i;
	logic [9:0] y_o;
	logic y_valid_o;
	logic [31:0] rd;
	int n_fail;
	int n_checks;
	int n_before;
	logic [11:0] idx_tab [8] = '{`LPP_IDX_MODE2, `LPP_IDX_BRIGHT, `LPP_IDX_CONTRAST,
		`LPP_IDX_LUMA_CTL, `LPP_IDX_HSCALE0, `LPP_IDX_HSCALE1, `LPP_IDX_HSCALE2, `LPP_IDX_WHITE3};
	logic [7:0] rst_tab [8] = '{8'h08, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	lpp_top lpp_top_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
		.dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
		.y_i(y_i), .y_valid_i(y_valid_i), .y_o(y_o), .y_valid_o(y_valid_o));
	lpp_stream_model lpp_stream_model_inst (.clk_i(clk_i), .res_i(y_o), .res_valid_i(y_valid_o),
		.samp_o(y_i), .samp_valid_o(y_valid_i));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One classic Wishbone cycle; read data lands in rd at the acknowledging edge.
	task automatic wb_cycle(input logic [11:0] idx, input logic w, input logic [3:0] sel,
		input logic [7:0] wd);
		int i;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		adr_i <= {idx, 2'b00};
		we_i <= w;
		sel_i <= sel;
		dat_i <= {24'h00_0000, wd};
		for (i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (ack_o === 1'b1) begin
				break;
			end
		end
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		if (i == 20) begin
			n_fail++;
			give_verdict();
		end
	endtask

	// Program the tail stages, stream a steady level and compare the settled output.
	task automatic run_case(input logic [7:0] ctl, input logic [7:0] con, input logic [7:0] bri,
		input logic [9:0] y, input logic [9:0] exp);
		int n0;
		wb_cycle(`LPP_IDX_LUMA_CTL, 1'b1, 4'hf, ctl);
		wb_cycle(`LPP_IDX_CONTRAST, 1'b1, 4'hf, con);
		wb_cycle(`LPP_IDX_BRIGHT, 1'b1, 4'hf, bri);
		n0 = lpp_stream_model_inst.n_out;
		lpp_stream_model_inst.send(y, 16);
		repeat (30) @(posedge clk_i);
		check({22'h00_0000, lpp_stream_model_inst.last_y}, {22'h00_0000, exp});
		check(32'(lpp_stream_model_inst.n_out - n0), 32'h0000_0010);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		n_fail = 0;
		n_checks = 0;
		rst_i = 1'b1;
		adr_i = 14'h0000;
		dat_i = 32'h0000_0000;
		we_i = 1'b0;
		sel_i = 4'h0;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int k = 0; k < 8; k++) begin
			wb_cycle(idx_tab[k], 1'b0, 4'hf, 8'h00);
			check(rd, {24'h00_0000, rst_tab[k]});
			wb_cycle(idx_tab[k], 1'b1, 4'hf, 8'ha5);
			wb_cycle(idx_tab[k], 1'b0, 4'hf, 8'h00);
			check(rd, 32'h0000_00a5);
			wb_cycle(idx_tab[k], 1'b1, 4'hf, 8'h00);
		end
		wb_cycle(12'h7ff, 1'b1, 4'hf, 8'h3c);
		wb_cycle(12'h7ff, 1'b0, 4'hf, 8'h00);
		check(rd, 32'h0000_0000);
		wb_cycle(`LPP_IDX_CONTRAST, 1'b1, 4'he, 8'h55);
		wb_cycle(`LPP_IDX_CONTRAST, 1'b0, 4'hf, 8'h00);
		check(rd, 32'h0000_0000);
		run_case(8'h20, 8'h00, 8'h10, 10'h200, 10'h080);
		run_case(8'h20, 8'h00, 8'h07, 10'h200, 10'h038);
		run_case(8'h23, 8'h00, 8'h07, 10'h200, 10'h000);
		run_case(8'h23, 8'h00, 8'h08, 10'h200, 10'h040);
		run_case(8'h00, 8'h00, 8'h00, 10'h200, 10'h040);
		run_case(8'h00, 8'h00, 8'h80, 10'h200, 10'h040);
		run_case(8'h10, 8'h00, 8'h80, 10'h200, 10'h004);
		run_case(8'h20, 8'h00, 8'h80, 10'h200, 10'h000);
		run_case(8'h00, 8'h80, 8'h7f, 10'h3ff, 10'h3f8);
		run_case(8'h20, 8'h80, 8'h7f, 10'h3ff, 10'h3ff);
		wb_cycle(`LPP_IDX_HSCALE0, 1'b1, 4'hf, 8'h01);
		run_case(8'h6c, 8'h80, 8'h00, 10'h200, 10'h1bf);
		wb_cycle(`LPP_IDX_STD, 1'b1, 4'hf, 8'h03);
		run_case(8'h20, 8'h80, 8'h00, 10'h200, 10'h16e);
		n_before = lpp_stream_model_inst.n_out;
		lpp_stream_model_inst.send(10'h200, 1);
		repeat (20) @(posedge clk_i);
		check(lpp_stream_model_inst.lat, 32'h0000_0009);
		check(32'(lpp_stream_model_inst.n_out - n_before), 32'h0000_0001);
		// Bright input with white limiting on: the gain steps down once per sample.
		wb_cycle(`LPP_IDX_MODE2, 1'b1, 4'hf, 8'h08);
		lpp_stream_model_inst.send(10'h3ff, 24);
		repeat (40) @(posedge clk_i);
		wb_cycle(`LPP_IDX_STATUS, 1'b0, 4'hf, 8'h00);
		check({24'h00_0000, rd[7:0]}, 32'h0000_0068);
		wb_cycle(`LPP_IDX_MODE2, 1'b1, 4'hf, 8'h00);
		wb_cycle(`LPP_IDX_STATUS, 1'b0, 4'hf, 8'h00);
		check({24'h00_0000, rd[7:0]}, 32'h0000_0080);
		wb_cycle(`LPP_IDX_WHITE3, 1'b1, 4'hf, 8'h01);
		wb_cycle(`LPP_IDX_MODE2, 1'b1, 4'hf, 8'h08);
		lpp_stream_model_inst.send(10'h3ff, 24);
		repeat (40) @(posedge clk_i);
		wb_cycle(`LPP_IDX_STATUS, 1'b0, 4'hf, 8'h00);
		check({24'h00_0000, rd[7:0]}, 32'h0000_006e);
		give_verdict();
	end
endmodule
